// >>> core/otp_lock_pkg.sv
// Purpose: shared constants for the sector lock and otp program block
// Assumes: 40 MHz system clock
// Notes: uid seed value is arbitrary
package otp_lock_pkg;
  localparam logic [7:0] OPC_OTP_PROG = 8'h9b;
  localparam int USER_BYTES = 128;
  localparam int OTP_AW = 7;
  localparam int LOCK_LOC = 127;
  localparam logic [7:0] ERASED = 8'hff;
  localparam int STAT_LOCK_POS = 7;
  localparam int GLB_MSB = 5;
  localparam int GLB_LSB = 2;
  localparam logic [3:0] GLB_CLR = 4'h0;
  localparam logic [3:0] GLB_SET = 4'hf;
  localparam logic [2:0] BYTE_ADDR_LAST = 3'h4;
  localparam logic [2:0] BYTE_DATA = 3'h5;
  localparam logic [2:0] BYTE_DATA_SEEN = 3'h6;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int FIFO_DEPTH = 32;
  localparam int CLK_PERIOD_NS = 25;
  localparam int PROG_TIME_NS = 100000;
  localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0] UID_SEED = 8'h5a;
  localparam logic [7:0] UID_STEP = 8'h2b;
endpackage

// >>> core/stream_fifo.sv
// Purpose: word fifo between serial receiver and program buffer
// Assumes: single clock, synchronous active-low reset
// Notes: show-ahead output
`timescale 1ns/1ps
module stream_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign o_out_data = mem[rd_ptr_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      if (push && !pop) begin
        count_reg <= count_reg + (AW+1)'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - (AW+1)'(1);
      end
    end
  end
endmodule

// >>> core/sector_lock_otp_program.sv
// Purpose: sector lock states and otp security area programming
// Assumes: link pins sampled on 40 MHz clock, spi mode 0
// Notes: protection commands arrive as strobes from the front-end
`timescale 1ns/1ps
module sector_lock_otp_program #(
  parameter int N_SECT = 8,
  parameter int PROG_CYC = otp_lock_pkg::PROG_CYCLES
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RSTN,
  input wire logic I_CS_N,
  input wire logic I_SCK,
  input wire logic I_SI,
  input wire logic I_WP_N,
  input wire logic I_OCTAL_MODE,
  input wire logic I_WREN,
  input wire logic I_STAT_WR,
  input wire logic [7:0] I_STAT_DATA,
  input wire logic I_SECT_WR,
  input wire logic I_SECT_PROT,
  input wire logic [$clog2(N_SECT)-1:0] I_SECT_IDX,
  input wire logic [7:0] I_RD_ADDR,
  output logic [N_SECT-1:0] O_SECT_PROT,
  output logic O_LOCK_BIT,
  output logic O_HW_LOCKED,
  output logic O_SW_LOCKED,
  output logic O_WEL,
  output logic O_BUSY,
  output logic O_OTP_LOCKED,
  output logic O_ABORT,
  output logic O_DONE,
  output logic O_RX_STALL,
  output logic [7:0] O_RD_DATA
);
  localparam int NU = otp_lock_pkg::USER_BYTES;
  localparam int AW = otp_lock_pkg::OTP_AW;
  localparam int TW = $clog2(PROG_CYC + 1);

  typedef enum logic [1:0] {ST_IDLE, ST_DRAIN, ST_PROG} state_type;
  state_type state_reg;

  logic cs_s1, cs_s2, cs_s3, sck_s1, sck_s2, sck_s3;
  logic si_s1, si_s2, wp_s1, wp_s2;
  logic [N_SECT-1:0] sect_reg;
  logic lock_reg, wel_reg, otp_lock_reg, frame_ok_reg;
  logic [2:0] bit_cnt_reg, bytes_reg;
  logic [7:0] shift_reg;
  logic opc_ok_reg, ovf_reg;
  logic [AW-1:0] addr_reg;
  logic [TW-1:0] timer_reg;
  logic [7:0] buf_data [NU];
  logic [NU-1:0] buf_valid;
  logic [7:0] otp_mem [NU];
  logic [NU-1:0] otp_prog;
  logic wp_active, hw_lock, sck_rise, cs_rise, cs_fall, byte_done;
  logic [7:0] byte_in;
  logic [3:0] glb;
  logic push, fifo_ready, f_valid, f_ready, commit, overlap;
  logic [AW+7:0] f_data;

  // pin synchronisers
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RSTN) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      si_s1 <= 1'b0;
      si_s2 <= 1'b0;
      wp_s1 <= 1'b1;
      wp_s2 <= 1'b1;
    end else begin
      cs_s1 <= I_CS_N;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      sck_s1 <= I_SCK;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      si_s1 <= I_SI;
      si_s2 <= si_s1;
      wp_s1 <= I_WP_N;
      wp_s2 <= wp_s1;
    end
  end

  assign wp_active = !I_OCTAL_MODE && !wp_s2;
  assign hw_lock = wp_active && lock_reg;
  assign glb = I_STAT_DATA[otp_lock_pkg::GLB_MSB:otp_lock_pkg::GLB_LSB];

  // lock bit and sector protection
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RSTN) begin
      lock_reg <= 1'b0;
      sect_reg <= '1;
    end else if (I_STAT_WR && !hw_lock) begin
      lock_reg <= I_STAT_DATA[otp_lock_pkg::STAT_LOCK_POS];
      if (!lock_reg && glb == otp_lock_pkg::GLB_CLR) begin
        sect_reg <= '0;
      end else if (!lock_reg && glb == otp_lock_pkg::GLB_SET) begin
        sect_reg <= '1;
      end
    end else if (I_SECT_WR && !lock_reg) begin
      sect_reg[I_SECT_IDX] <= I_SECT_PROT;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RSTN) begin
      O_HW_LOCKED <= 1'b0;
      O_SW_LOCKED <= 1'b0;
    end else begin
      O_HW_LOCKED <= hw_lock;
      O_SW_LOCKED <= lock_reg && !wp_active;
    end
  end

  assign sck_rise = sck_s2 && !sck_s3;
  assign cs_fall = !cs_s2 && cs_s3;
  assign cs_rise = cs_s2 && !cs_s3;
  assign byte_in = {shift_reg[6:0], si_s2};
  assign byte_done = sck_rise && !cs_s2 && state_reg == ST_IDLE &&
    bit_cnt_reg == otp_lock_pkg::BIT_LAST;
  assign push = byte_done && opc_ok_reg &&
    bytes_reg >= otp_lock_pkg::BYTE_DATA;

  // serial receiver
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RSTN) begin
      bit_cnt_reg <= '0;
      bytes_reg <= '0;
      shift_reg <= '0;
      opc_ok_reg <= 1'b0;
      ovf_reg <= 1'b0;
      addr_reg <= '0;
    end else if (cs_fall) begin
      bit_cnt_reg <= '0;
      bytes_reg <= '0;
      opc_ok_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else if (sck_rise && !cs_s2 && state_reg == ST_IDLE) begin
      shift_reg <= byte_in;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (byte_done) begin
        if (bytes_reg != otp_lock_pkg::BYTE_DATA_SEEN) begin
          bytes_reg <= bytes_reg + 3'h1;
        end
        if (bytes_reg == '0) begin
          opc_ok_reg <= byte_in == otp_lock_pkg::OPC_OTP_PROG;
        end
        if (bytes_reg == otp_lock_pkg::BYTE_ADDR_LAST) begin
          addr_reg <= byte_in[AW-1:0];
        end
        if (push) begin
          addr_reg <= addr_reg + AW'(1);
          if (!fifo_ready) begin
            ovf_reg <= 1'b1;
          end
        end
      end
    end
  end

  stream_fifo #(.WIDTH(AW + 8), .DEPTH(otp_lock_pkg::FIFO_DEPTH)) u_fifo (
    .i_clk(I_CLK_SYS),
    .i_rstn(I_RSTN),
    .i_in_valid(push),
    .i_in_data({addr_reg, byte_in}),
    .o_in_ready(fifo_ready),
    .o_out_valid(f_valid),
    .o_out_data(f_data),
    .i_out_ready(f_ready)
  );

  assign f_ready = state_reg != ST_PROG && !cs_fall;
  assign commit = state_reg == ST_PROG && timer_reg == '0;
  assign overlap = |(buf_valid & otp_prog);

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RSTN) begin
      O_RX_STALL <= 1'b0;
    end else begin
      O_RX_STALL <= !fifo_ready;
    end
  end

  // buffer entries and otp area
  genvar gi;
  generate
    for (gi = 0; gi < NU; gi++) begin : g_ent
      always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
          buf_valid[gi] <= 1'b0;
          otp_prog[gi] <= 1'b0;
        end else begin
          if (cs_fall && state_reg == ST_IDLE) begin
            buf_valid[gi] <= 1'b0;
          end else if (f_valid && f_ready &&
                       f_data[AW+7:8] == AW'(gi)) begin
            buf_valid[gi] <= 1'b1;
          end
          if (commit && buf_valid[gi]) begin
            otp_prog[gi] <= 1'b1;
          end
        end
      end
      always_ff @(posedge I_CLK_SYS) begin
        if (f_valid && f_ready && f_data[AW+7:8] == AW'(gi)) begin
          buf_data[gi] <= f_data[7:0];
        end
        if (commit && buf_valid[gi]) begin
          otp_mem[gi] <= buf_data[gi];
        end
      end
    end
  endgenerate

  // command sequencing
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RSTN) begin
      state_reg <= ST_IDLE;
      wel_reg <= 1'b0;
      otp_lock_reg <= 1'b0;
      frame_ok_reg <= 1'b0;
      timer_reg <= '0;
      O_ABORT <= 1'b0;
      O_DONE <= 1'b0;
    end else begin
      O_ABORT <= 1'b0;
      O_DONE <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (I_WREN) begin
            wel_reg <= 1'b1;
          end
          if (cs_rise && opc_ok_reg) begin
            frame_ok_reg <= bytes_reg == otp_lock_pkg::BYTE_DATA_SEEN &&
              bit_cnt_reg == '0 && !ovf_reg;
            state_reg <= ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          if (!f_valid) begin
            wel_reg <= 1'b0;
            if (frame_ok_reg && wel_reg && !otp_lock_reg &&
                !overlap) begin
              timer_reg <= TW'(PROG_CYC - 1);
              state_reg <= ST_PROG;
            end else begin
              O_ABORT <= 1'b1;
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_PROG: begin
          if (timer_reg == '0) begin
            if (buf_valid[otp_lock_pkg::LOCK_LOC]) begin
              otp_lock_reg <= 1'b1;
            end
            O_DONE <= 1'b1;
            state_reg <= ST_IDLE;
          end else begin
            timer_reg <= timer_reg - TW'(1);
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // read-back of otp area, upper half is fixed
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RSTN) begin
      O_RD_DATA <= otp_lock_pkg::ERASED;
    end else if (I_RD_ADDR[AW]) begin
      O_RD_DATA <= otp_lock_pkg::UID_SEED ^
        8'({1'b0, I_RD_ADDR[AW-1:0]} * otp_lock_pkg::UID_STEP);
    end else if (otp_prog[I_RD_ADDR[AW-1:0]]) begin
      O_RD_DATA <= otp_mem[I_RD_ADDR[AW-1:0]];
    end else begin
      O_RD_DATA <= otp_lock_pkg::ERASED;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RSTN) begin
      O_BUSY <= 1'b0;
    end else begin
      O_BUSY <= state_reg != ST_IDLE;
    end
  end

  assign O_SECT_PROT = sect_reg;
  assign O_LOCK_BIT = lock_reg;
  assign O_WEL = wel_reg;
  assign O_OTP_LOCKED = otp_lock_reg;

  // checks
  AST_HW_FREEZE: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    hw_lock && (I_STAT_WR || I_SECT_WR) |=> $stable(sect_reg) &&
    $stable(lock_reg)) else $error("hw lock changed state");
  AST_HW_FLAG: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    ##1 O_HW_LOCKED == $past(!I_OCTAL_MODE && !wp_s2 && lock_reg))
    else $error("hw lock flag wrong");
  AST_SOFT_NOGLB: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    I_STAT_WR && lock_reg && !hw_lock |=> $stable(sect_reg))
    else $error("global applied while locked");
  AST_GLB_CLR: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    I_STAT_WR && !lock_reg && glb == otp_lock_pkg::GLB_CLR |=>
    sect_reg == '0) else $error("global clear missed");
  AST_ABORT_WEL: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    O_ABORT |-> !wel_reg && state_reg == ST_IDLE)
    else $error("abort left latch set");
  AST_PROG_WEL: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    state_reg == ST_PROG |-> !wel_reg ##1 O_BUSY)
    else $error("latch set while programming");
  AST_LOCK_REFUSE: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    state_reg == ST_DRAIN && !f_valid && otp_lock_reg |=> O_ABORT)
    else $error("locked area not refused");
  AST_WEL_GATE: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    state_reg == ST_DRAIN && !f_valid && !wel_reg |=> O_ABORT)
    else $error("program without latch");
  AST_LOCK_SET: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    commit && buf_valid[otp_lock_pkg::LOCK_LOC] |=> otp_lock_reg && O_DONE)
    else $error("area not locked");
  COV_DONE: cover property (@(posedge I_CLK_SYS) O_DONE);
  COV_ABORT: cover property (@(posedge I_CLK_SYS) O_ABORT);
  COV_HWLOCK: cover property (@(posedge I_CLK_SYS) hw_lock && I_STAT_WR);
endmodule

// >>> tb/host_link_model.sv
// Purpose: host controller model driving the serial link
// Assumes: mode 0, sck idle low, sck period 8 system clocks (200 ns)
// Notes: si inverted on release so a stale bit never looks valid
`timescale 1ns/1ps
module host_link_model (
  input wire logic i_clk,
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si
);
  logic [7:0] tx_q[$];
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
  end
  // opcode, four address bytes, then data bytes, msb first
  task automatic frame(input int nbits);
    int i;
    @(negedge i_clk);
    o_cs_n = 1'b0;
    repeat (4) @(negedge i_clk);
    for (i = 0; i < nbits; i++) begin
      o_si = tx_q[i / 8][7 - (i % 8)];
      repeat (4) @(negedge i_clk);
      o_sck = 1'b1;
      repeat (4) @(negedge i_clk);
      o_sck = 1'b0;
    end
    repeat (4) @(negedge i_clk);
    o_cs_n = 1'b1;
    o_si = ~o_si;
    tx_q.delete();
  endtask
endmodule

// >>> tb/sector_lock_otp_program_tb_top.sv
// Purpose: self-checking bench for lock states and otp programming
// Assumes: program time shortened to 20 cycles
// Notes: inputs change on the falling clock edge
`timescale 1ns/1ps
module sector_lock_otp_program_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cs_n, sck, si;
  logic wp_n = 1'b1;
  logic octal = 1'b0;
  logic wren = 1'b0;
  logic stat_wr = 1'b0;
  logic [7:0] stat_data = 8'h00;
  logic sect_wr = 1'b0;
  logic sect_prot = 1'b0;
  logic [2:0] sect_idx = 3'h0;
  logic [7:0] rd_addr = 8'h00;
  logic [7:0] sect, rd_data;
  logic lock, hw_lk, sw_lk, write_enable_latch, busy, otp_lk, abort, done, stall;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #12.5 clk = ~clk;

  host_link_model host (.i_clk(clk), .o_cs_n(cs_n), .o_sck(sck), .o_si(si));

  sector_lock_otp_program #(.N_SECT(8), .PROG_CYC(20)) uut (
    .I_CLK_SYS(clk), .I_RSTN(rstn), .I_CS_N(cs_n), .I_SCK(sck),
    .I_SI(si), .I_WP_N(wp_n), .I_OCTAL_MODE(octal), .I_WREN(wren),
    .I_STAT_WR(stat_wr), .I_STAT_DATA(stat_data), .I_SECT_WR(sect_wr),
    .I_SECT_PROT(sect_prot), .I_SECT_IDX(sect_idx), .I_RD_ADDR(rd_addr),
    .O_SECT_PROT(sect), .O_LOCK_BIT(lock), .O_HW_LOCKED(hw_lk),
    .O_SW_LOCKED(sw_lk), .O_WEL(write_enable_latch), .O_BUSY(busy),
    .O_OTP_LOCKED(otp_lk), .O_ABORT(abort), .O_DONE(done),
    .O_RX_STALL(stall), .O_RD_DATA(rd_data)
  );

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      test_done;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic sw(input logic [7:0] d);
    @(negedge clk);
    stat_data = d;
    stat_wr = 1'b1;
    @(negedge clk);
    stat_wr = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic ss(input logic [2:0] idx, input logic p);
    @(negedge clk);
    sect_idx = idx;
    sect_prot = p;
    sect_wr = 1'b1;
    @(negedge clk);
    sect_wr = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    rd_addr = a;
    repeat (2) @(negedge clk);
    chk(rd_data, exp);
  endtask

  task automatic set_wel;
    @(negedge clk);
    wren = 1'b1;
    @(negedge clk);
    wren = 1'b0;
    @(negedge clk);
    chk(write_enable_latch, 1'b1);
  endtask

  task automatic otp(input logic [31:0] a, input int nd, input int extra,
                     input logic [23:0] d, input logic exp_abort);
    int k;
    logic seen_busy;
    logic seen_abort;
    seen_busy = 1'b0;
    seen_abort = 1'b0;
    host.tx_q.push_back(otp_lock_pkg::OPC_OTP_PROG);
    for (k = 3; k >= 0; k--) host.tx_q.push_back(a[k*8 +: 8]);
    for (k = 0; k < nd; k++) host.tx_q.push_back(d[23-k*8 -: 8]);
    host.tx_q.push_back(8'ha5);
    host.frame(40 + nd * 8 + extra);
    for (k = 0; k < 400; k++) begin
      @(negedge clk);
      if (busy === 1'b1) seen_busy = 1'b1;
      if (abort === 1'b1) seen_abort = 1'b1;
      if (done === 1'b1 || abort === 1'b1) break;
    end
    chk(k < 400, 1'b1);
    chk(seen_abort, exp_abort);
    chk(write_enable_latch, 1'b0);
    if (!exp_abort) chk(seen_busy, 1'b1);
    repeat (4) @(negedge clk);
    chk(busy, 1'b0);
    chk(stall, 1'b0);
  endtask

  task automatic t_reset;
    chk(sect, 8'hff);
    chk(lock, 1'b0);
    chk(write_enable_latch, 1'b0);
    chk(busy, 1'b0);
    chk(otp_lk, 1'b0);
    chk(hw_lk, 1'b0);
  endtask

  task automatic t_prot;
    sw(8'h00);
    chk(sect, 8'h00);
    chk(lock, 1'b0);
    sw(8'h7f);
    chk(sect, 8'hff);
    ss(3'd3, 1'b0);
    chk(sect, 8'hf7);
    sw(8'hf0);
    chk(lock, 1'b1);
    chk(sect, 8'hf7);
    chk(sw_lk, 1'b1);
    ss(3'd3, 1'b1);
    chk(sect, 8'hf7);
    sw(8'h3c);
    chk(lock, 1'b0);
    chk(sect, 8'hf7);
    sw(8'h80);
    chk(lock, 1'b1);
    chk(sect, 8'h00);
  endtask

  task automatic t_lock;
    @(negedge clk);
    wp_n = 1'b0;
    repeat (6) @(negedge clk);
    chk(hw_lk, 1'b1);
    sw(8'h00);
    chk(lock, 1'b1);
    ss(3'd0, 1'b1);
    chk(sect, 8'h00);
    octal = 1'b1;
    repeat (6) @(negedge clk);
    chk(hw_lk, 1'b0);
    chk(sw_lk, 1'b1);
    sw(8'h7c);
    chk(lock, 1'b0);
    chk(sect, 8'h00);
    octal = 1'b0;
    wp_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask

  task automatic t_otp;
    otp(32'h20, 1, 0, 24'h330000, 1'b1);
    rd(8'h20, 8'hff);
    set_wel;
    otp(32'h20, 1, 3, 24'h330000, 1'b1);
    set_wel;
    otp(32'h20, 0, -8, 24'h0, 1'b1);
    rd(8'h20, 8'hff);
    set_wel;
    otp(32'hffffff90, 2, 0, 24'h112200, 1'b0);
    rd(8'h10, 8'h11);
    rd(8'h11, 8'h22);
    rd(8'h12, 8'hff);
    chk(otp_lk, 1'b0);
    set_wel;
    otp(32'h11, 1, 0, 24'h440000, 1'b1);
    rd(8'h11, 8'h22);
    set_wel;
    otp(32'h7e, 3, 0, 24'h010203, 1'b0);
    chk(otp_lk, 1'b1);
    rd(8'h7e, 8'h01);
    rd(8'h7f, 8'h02);
    rd(8'h00, 8'h03);
    rd(8'h01, 8'hff);
    set_wel;
    otp(32'h40, 1, 0, 24'h550000, 1'b1);
    rd(8'h40, 8'hff);
    rd(8'h80, otp_lock_pkg::UID_SEED);
  endtask

  initial begin
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    t_reset;
    t_prot;
    t_lock;
    t_otp;
    test_done;
  end
endmodule
